/* File: src/burst4_sram_pkg.sv */
package burst4_sram_pkg;

    localparam int DATA_W  = 18;
    localparam int LANE_W  = 9;
    localparam int BURST   = 4;
    localparam int LANES   = 8;
    localparam int LINE_W  = 72;
    // documented depth is 21 address bits; kept small so a bench can run
    localparam int ADDR_W  = 10;

    // half-cycle ticks from request to first read word, minus one
    localparam logic [1:0] LAT2_TICKS_M1 = 2'h3;
    localparam logic [1:0] LAT1_TICKS_M1 = 2'h1;
    // half-cycle ticks from write request to first write word, minus one
    localparam logic [1:0] WR_TICKS_M1   = 2'h1;
    localparam logic [1:0] LAST_WORD     = 2'h3;

    typedef struct packed {
        logic              v;
        logic [ADDR_W-1:0] addr;
        logic [1:0]        cnt;
    } slot_s;

    typedef struct packed {
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [LINE_W-1:0] data;
        logic [LANES-1:0]  mask;
    } line_wr_s;

endpackage

/* File: src/burst_line_mem.sv */
module burst_line_mem (
    input  wire logic                                  mclk_i,
    input  wire burst4_sram_pkg::line_wr_s             wr_i,
    input  wire logic [burst4_sram_pkg::ADDR_W-1:0]    rd_addr_i,
    output logic      [burst4_sram_pkg::LINE_W-1:0]    rd_data_o
);
    localparam int DEPTH = 2 ** burst4_sram_pkg::ADDR_W;
    localparam int LW    = burst4_sram_pkg::LANE_W;

    // four words side by side in one array, one line per address
    logic [burst4_sram_pkg::LINE_W-1:0] mem [DEPTH];

    always_ff @(posedge mclk_i) begin
        if (wr_i.we) begin
            for (int j = 0; j < burst4_sram_pkg::LANES; j++) begin
                if (wr_i.mask[j]) begin
                    mem[wr_i.addr][j*LW +: LW] <= wr_i.data[j*LW +: LW];
                end
            end
        end
    end

    assign rd_data_o = mem[rd_addr_i];
endmodule

/* File: src/burst4_sram_access.sv */
module burst4_sram_access (
    input  wire logic                                  mclk_i,
    input  wire logic                                  rst_i,
    input  wire logic                                  pll_disable_n_i,
    input  wire logic                                  read_port_select_n_i,
    input  wire logic                                  write_port_select_n_i,
    input  wire logic [burst4_sram_pkg::ADDR_W-1:0]    addr_i,
    input  wire logic [burst4_sram_pkg::DATA_W-1:0]    d_i,
    input  wire logic [1:0]                            byte_write_select_n_i,
    output logic      [burst4_sram_pkg::DATA_W-1:0]    q_o,
    output logic                                       q_oe_o,
    output logic                                       output_valid_flag_o,
    output logic                                       kbar_phase_o
);
    localparam int DW = burst4_sram_pkg::DATA_W;
    localparam int LW = burst4_sram_pkg::LANE_W;

    typedef struct packed {
        logic                              kbar_phase;
        logic                              prev_rd;
        logic                              prev_wr;
        burst4_sram_pkg::slot_s            rp;
        burst4_sram_pkg::slot_s            ro;
        burst4_sram_pkg::slot_s            wp;
        burst4_sram_pkg::slot_s            wc;
        logic [burst4_sram_pkg::LINE_W-1:0] wbuf;
        logic [burst4_sram_pkg::LANES-1:0]  wmask;
        burst4_sram_pkg::line_wr_s         cm;
        logic [DW-1:0]                     q;
        logic                              q_oe;
        logic                              vld;
    } state_s;

    state_s s_r;
    state_s s_nxt;

    logic [burst4_sram_pkg::ADDR_W-1:0] fetch_addr;
    logic [burst4_sram_pkg::LINE_W-1:0] mem_line;
    logic [burst4_sram_pkg::LINE_W-1:0] fwd_line;
    logic                               k_rise;
    logic                               rd_go;
    logic                               wr_go;

    function automatic logic [burst4_sram_pkg::LINE_W-1:0] merge_line(
        input logic [burst4_sram_pkg::LINE_W-1:0] base,
        input logic [burst4_sram_pkg::LINE_W-1:0] upd,
        input logic [burst4_sram_pkg::LANES-1:0]  mask
    );
        logic [burst4_sram_pkg::LINE_W-1:0] r;
        r = base;
        for (int j = 0; j < burst4_sram_pkg::LANES; j++) begin
            if (mask[j]) begin
                r[j*LW +: LW] = upd[j*LW +: LW];
            end
        end
        return r;
    endfunction

    function automatic logic [DW-1:0] word_of(
        input logic [burst4_sram_pkg::LINE_W-1:0] line,
        input logic [1:0]                         idx
    );
        return line[idx*DW +: DW];
    endfunction

    burst_line_mem u_mem (
        .mclk_i    (mclk_i),
        .wr_i      (s_r.cm),
        .rd_addr_i (fetch_addr),
        .rd_data_o (mem_line)
    );

    // one memory read port: pending read only fetches on its launch edge
    assign fetch_addr = (s_r.rp.v && s_r.rp.cnt == 2'h0) ? s_r.rp.addr
                                                          : s_r.ro.addr;

    // newest data wins: array, then committing line, then partial burst
    always_comb begin
        fwd_line = merge_line(mem_line, s_r.cm.data,
            s_r.cm.mask & {burst4_sram_pkg::LANES{
                s_r.cm.we && s_r.cm.addr == fetch_addr}});
        fwd_line = merge_line(fwd_line, s_r.wbuf,
            s_r.wmask & {burst4_sram_pkg::LANES{
                s_r.wc.v && s_r.wc.addr == fetch_addr}});
    end

    // even ticks are positive-clock rises, odd ticks negative-clock rises
    assign k_rise = ~s_r.kbar_phase;

    always_comb begin
        s_nxt            = s_r;
        s_nxt.kbar_phase = ~s_r.kbar_phase;
        s_nxt.q_oe       = 1'b0;
        s_nxt.cm.we      = 1'b0;
        rd_go            = 1'b0;
        wr_go            = 1'b0;

        // read output slot: one word every tick
        if (s_r.ro.v) begin
            s_nxt.q      = word_of(fwd_line, s_r.ro.cnt);
            s_nxt.q_oe   = 1'b1;
            s_nxt.ro.cnt = s_r.ro.cnt + 2'h1;
            if (s_r.ro.cnt == burst4_sram_pkg::LAST_WORD) begin
                s_nxt.ro.v = 1'b0;
            end
        end

        // read pending slot: wait out the latency, then launch word 0
        if (s_r.rp.v) begin
            if (s_r.rp.cnt == 2'h0) begin
                s_nxt.q    = word_of(fwd_line, 2'h0);
                s_nxt.q_oe = 1'b1;
                s_nxt.ro   = '{v: 1'b1, addr: s_r.rp.addr, cnt: 2'h1};
                s_nxt.rp.v = 1'b0;
            end else begin
                s_nxt.rp.cnt = s_r.rp.cnt - 2'h1;
            end
        end

        // flag leads word 0 by one tick, drops as the last word goes out
        s_nxt.vld = (s_r.rp.v && s_r.rp.cnt <= 2'h1) ||
                    (s_r.ro.v && s_r.ro.cnt != burst4_sram_pkg::LAST_WORD);

        // write pending slot: first word one full cycle after request
        if (s_r.wp.v) begin
            if (s_r.wp.cnt == 2'h0) begin
                s_nxt.wc    = '{v: 1'b1, addr: s_r.wp.addr, cnt: 2'h0};
                s_nxt.wmask = '0;
                s_nxt.wp.v  = 1'b0;
            end else begin
                s_nxt.wp.cnt = s_r.wp.cnt - 2'h1;
            end
        end

        // capture one word and its byte selects per tick
        if (s_nxt.wc.v) begin
            s_nxt.wbuf[s_nxt.wc.cnt*DW +: DW] = d_i;
            s_nxt.wmask[s_nxt.wc.cnt*2 +: 2] = ~byte_write_select_n_i;
            s_nxt.wc.cnt = s_nxt.wc.cnt + 2'h1;
            if (s_nxt.wc.cnt == 2'h0) begin
                // all four words in: commit the line under its byte mask next tick
                s_nxt.cm = '{we: 1'b1, addr: s_nxt.wc.addr,
                             data: s_nxt.wbuf, mask: s_nxt.wmask};
                s_nxt.wc.v = 1'b0;
            end
        end

        // request acceptance on positive-clock rises only
        if (k_rise) begin
            rd_go = !read_port_select_n_i && !s_r.prev_rd;
            wr_go = !write_port_select_n_i && !s_r.prev_wr && !rd_go;
            s_nxt.prev_rd = rd_go;
            s_nxt.prev_wr = wr_go;
            if (rd_go) begin
                s_nxt.rp = '{v: 1'b1, addr: addr_i,
                             cnt: pll_disable_n_i
                                  ? burst4_sram_pkg::LAT2_TICKS_M1
                                  : burst4_sram_pkg::LAT1_TICKS_M1};
            end
            if (wr_go) begin
                s_nxt.wp = '{v: 1'b1, addr: addr_i,
                             cnt: burst4_sram_pkg::WR_TICKS_M1};
            end
        end
    end

    // reset leaves both ports idle and the outputs released
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q_o                 = s_r.q;
    assign q_oe_o              = s_r.q_oe;
    assign output_valid_flag_o = s_r.vld;
    assign kbar_phase_o        = s_r.kbar_phase;
endmodule

/* File: sim/burst4_sram_monitor.sv */
module burst4_sram_monitor (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic pll_disable_n_i,
    input wire logic read_port_select_n_i,
    input wire logic q_oe_o,
    input wire logic output_valid_flag_o,
    input wire logic kbar_phase_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic rd_prev_r;
    logic acc;
    // a read on the next rise is refused, so it starts nothing
    assign acc = !kbar_phase_o && !read_port_select_n_i && !rd_prev_r;
    always_ff @(posedge mclk_i) begin
        if (rst_i) rd_prev_r <= 1'b0;
        else if (!kbar_phase_o) rd_prev_r <= acc;
    end
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    chk_reset_idle: assert property (disable iff (1'b0)
        rst_i |=> !q_oe_o && !output_valid_flag_o && !kbar_phase_o)
        else $error("outputs busy after reset");
    chk_phase_flip: assert property (
        !rst_i |=> kbar_phase_o != $past(kbar_phase_o)) else $error("phase");
    chk_read_lat2: assert property (acc && pll_disable_n_i
        |-> ##4 output_valid_flag_o ##1 q_oe_o [*4]) else $error("lat2");
    chk_read_lat1: assert property (acc && !pll_disable_n_i
        |-> ##2 output_valid_flag_o ##1 q_oe_o [*4]) else $error("lat1");
    chk_flag_lead: assert property ($rose(q_oe_o)
        |-> $past(output_valid_flag_o)) else $error("data before flag");
    chk_flag_data: assert property ($rose(output_valid_flag_o)
        |=> q_oe_o) else $error("flag without data");
    chk_burst_len: assert property ($rose(q_oe_o)
        |-> q_oe_o [*4]) else $error("short burst");
    chk_oe_off: assert property ($fell(output_valid_flag_o)
        |=> !q_oe_o) else $error("outputs not released");
    cover property (acc && pll_disable_n_i);
    cover property (acc && !pll_disable_n_i);
    cover property (!kbar_phase_o && !read_port_select_n_i && rd_prev_r);
endmodule

bind burst4_sram_access burst4_sram_monitor burst4_sram_monitor_i (
    .mclk_i(mclk_i), .rst_i(rst_i), .pll_disable_n_i(pll_disable_n_i),
    .read_port_select_n_i(read_port_select_n_i), .q_oe_o(q_oe_o),
    .output_valid_flag_o(output_valid_flag_o), .kbar_phase_o(kbar_phase_o));

/* File: sim/ctrl_model.sv */
module ctrl_model (
    input  wire logic        mclk_i,
    input  wire logic        kbar_phase_i,
    input  wire logic [17:0] q_i,
    output logic             rps_n_o,
    output logic             wps_n_o,
    output logic [9:0]       addr_o,
    output logic [17:0]      d_o,
    output logic [1:0]       bws_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {rps_n_o, wps_n_o, bws_n_o} = 4'hF;
    initial {addr_o, d_o} = '0;
    task automatic go;
        do @(negedge mclk_i); while (kbar_phase_i !== 1'b1);
        @(posedge mclk_i);
    endtask
    task automatic wr(input logic [9:0] a, logic [71:0] w, logic [7:0] m);
        go;
        wps_n_o <= 1'b0;
        addr_o <= a;
        @(posedge mclk_i);
        wps_n_o <= 1'b1;
        addr_o <= ~a;
        for (int k = 0; k < 4; k++) begin
            @(posedge mclk_i);
            d_o <= w[18*k +: 18];
            bws_n_o <= m[2*k +: 2];
        end
        @(posedge mclk_i);
        d_o <= ~w[71:54];
        bws_n_o <= 2'h3;
    endtask
    task automatic rd(input logic [9:0] a, int lat, logic dup,
                      output logic [71:0] r);
        go;
        rps_n_o <= 1'b0;
        addr_o <= a;
        @(posedge mclk_i);
        rps_n_o <= ~dup;
        addr_o <= ~a;
        repeat (2) @(posedge mclk_i);
        rps_n_o <= 1'b1;
        repeat (lat - 2) @(posedge mclk_i);
        for (int k = 0; k < 4; k++) begin
            #1 r[18*k +: 18] = q_i;
            @(posedge mclk_i);
        end
    endtask
    // both selects held over three rises: read, write, read to one line
    task automatic rwr(input logic [9:0] a, logic [71:0] w,
                       output logic [143:0] r);
        go;
        {rps_n_o, wps_n_o} <= 2'h0;
        addr_o <= a;
        repeat (4) @(posedge mclk_i);
        for (int k = 0; k < 9; k++) begin
            if (k < 4) d_o <= w[18*k +: 18];
            bws_n_o <= (k < 4) ? 2'h0 : 2'h3;
            if (k == 1) {rps_n_o, wps_n_o} <= 2'h3;
            if (k > 0) #1 r[18*(k-1) +: 18] = q_i;
            @(posedge mclk_i);
        end
    endtask
endmodule

/* File: sim/burst4_dual_port_sram_access_tb.sv */
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin \
    miscompares++; \
    $display("unexpected at %0t: got %0h exp %0h", $time, a, e); end end
module burst4_dual_port_sram_access_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic        s;
        logic [9:0]  a;
        logic [71:0] w;
        logic [7:0]  m;
    } row_s;
    row_s rows [6] = '{'{1'b1, 10'h005, 72'h123456789ABCDEF012, 8'h00},
        '{1'b0, 10'h005, 72'hFFFFFFFFFFFFFFFFFF, 8'hAA},
        '{1'b1, 10'h005, 72'h000000000000000000, 8'h55},
        '{1'b0, 10'h3FF, 72'hABCDEF0123456789AB, 8'h00},
        '{1'b1, 10'h3FF, 72'hFEDCBA987654321000, 8'hFF},
        '{1'b1, 10'h000, 72'h0F0F0F0F0F0F0F0F0F, 8'h00}};
    logic        mclk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        pll = 1'b1;
    logic        rps_n, wps_n, q_oe, vld, kph;
    logic [9:0]  addr;
    logic [17:0] d, q;
    logic [1:0]  byte_write_select_n;
    logic [71:0] r, sh [1024];
    logic [143:0] r2;
    int          miscompares, num_checks, cyc, oe_n, b;
    burst4_sram_access burst4_sram_access_i (.mclk_i(mclk_i), .rst_i(rst_i),
        .pll_disable_n_i(pll), .read_port_select_n_i(rps_n),
        .write_port_select_n_i(wps_n), .addr_i(addr), .d_i(d),
        .byte_write_select_n_i(byte_write_select_n), .q_o(q), .q_oe_o(q_oe),
        .output_valid_flag_o(vld), .kbar_phase_o(kph));
    ctrl_model ctrl_model_i (.mclk_i(mclk_i), .kbar_phase_i(kph), .q_i(q),
        .rps_n_o(rps_n), .wps_n_o(wps_n), .addr_o(addr), .d_o(d),
        .bws_n_o(byte_write_select_n));
    function automatic logic [71:0] mg(logic [71:0] o, n, logic [7:0] m);
        for (int i = 0; i < 8; i++) if (!m[i]) o[9*i +: 9] = n[9*i +: 9];
        return o;
    endfunction
    task automatic close_out;
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic reset_for(input int n);
        @(posedge mclk_i) rst_i <= 1'b1;
        repeat (n) @(posedge mclk_i);
        #1 `CHK({q_oe, vld, kph}, 3'h0)
        @(posedge mclk_i) rst_i <= 1'b0;
        $display("reset test done");
    endtask
    always #5 mclk_i = ~mclk_i;
    // generous ceiling: the whole run needs under two hundred cycles
    always @(posedge mclk_i) begin
        cyc++;
        if (q_oe === 1'b1) oe_n++;
        if (cyc == 1000) begin miscompares++; close_out(); end
    end
    initial begin
        reset_for(8);
        foreach (rows[i]) begin
            @(posedge mclk_i) pll <= rows[i].s;
            ctrl_model_i.wr(rows[i].a, rows[i].w, rows[i].m);
            sh[rows[i].a] = mg(sh[rows[i].a], rows[i].w, rows[i].m);
            b = oe_n;
            ctrl_model_i.rd(rows[i].a, rows[i].s ? 4 : 2, i[0], r);
            @(posedge mclk_i);
            #1 `CHK(r, sh[rows[i].a])
            `CHK(oe_n - b, 4)
            $display("row %0d done", i);
        end
        b = oe_n;
        ctrl_model_i.rwr(10'h3FF, 72'h2468ACE013579BDF02, r2);
        `CHK(r2[71:0], sh[10'h3FF])
        sh[10'h3FF] = 72'h2468ACE013579BDF02;
        @(posedge mclk_i);
        #1 `CHK(r2[143:72], sh[10'h3FF])
        `CHK(oe_n - b, 8)
        $display("arbitration test done");
        reset_for(2);
        ctrl_model_i.rd(10'h005, 4, 1'b0, r);
        `CHK(r, sh[10'h005])
        $display("read after reset done");
        close_out();
    end
endmodule
